// *** inc/l1cfg_pkg.sv ***
// Purpose: Shared constants of the level-one cache configuration block.
// Assumes: One 32-bit configuration word on a classic Wishbone slave.
// Notes: Bit positions, masks, reset value and size coding live here; the bench repeats bit positions and size coding.
//
// Behaviour
// - With fast_irq_fill_bypass_en set and an interrupt pending, every cache fill decision becomes an uncached access.
// - The pm_writeback_en bit turns on write-back operation of the program-memory cache.
// - Writing one to pm_invalidate invalidates the program-memory cache entries.
// - pm_lock_way_one and pm_lock_way_zero each lock their program-memory way while set.
// - pm_size_sel picks 128K, 256K, 512K or 1M bits for the program-memory cache.
// - The dm_writeback_en bit turns on write-back operation of the data-memory cache.
// - Writing one to dm_invalidate invalidates the data-memory cache entries.
// - dm_lock_way_one and dm_lock_way_zero each lock their data-memory way while set.
// - dm_size_sel picks 128K, 256K, 512K or 1M bits for the data-memory cache.
// - Bit 0 turns on the instruction cache, alone or with both other caches.
// - Bit 8 turns on the data-memory cache, which runs only with the other two caches on.
package l1cfg_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned KB_W = 11;
	localparam logic [7:0] CFG_OFFSET = 8'h00;
	localparam logic [31:0] CFG_RESET = 32'h00000000;
	localparam logic [31:0] CFG_RW_MASK = 32'h01f7f701;
	localparam int unsigned B_IC_ON = 0;
	localparam int unsigned B_DM_ON = 8;
	localparam int unsigned B_DM_SIZE = 9;
	localparam int unsigned B_DM_LCK0 = 12;
	localparam int unsigned B_DM_LCK1 = 13;
	localparam int unsigned B_DM_INV = 14;
	localparam int unsigned B_DM_WB = 15;
	localparam int unsigned B_PM_ON = 16;
	localparam int unsigned B_PM_SIZE = 17;
	localparam int unsigned B_PM_LCK0 = 20;
	localparam int unsigned B_PM_LCK1 = 21;
	localparam int unsigned B_PM_INV = 22;
	localparam int unsigned B_PM_WB = 23;
	localparam int unsigned B_FIRQ = 24;
	localparam int unsigned FILL_IC = 0;
	localparam int unsigned FILL_PM = 1;
	localparam int unsigned FILL_DM = 2;
	localparam logic [10:0] SIZE_BASE_KBITS = 11'h080;

	// Size code n selects 128K bits shifted left by n.
	function automatic logic [KB_W-1:0] size_kbits(input logic [1:0] code);
		return SIZE_BASE_KBITS << code;
	endfunction

	function automatic logic [DATA_W-1:0] be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction
endpackage

// *** inc/cfg_bus_if.sv ***
// Purpose: Carrier between the Wishbone port and the configuration register.
// Assumes: One clock; wr is a one-cycle strobe already decoded for the register.
// Notes: rdat always shows the register as software reads it.
`timescale 1ns/1ps
`default_nettype none
interface cfg_bus_if;
	logic wr;
	logic [31:0] wdat;
	logic [3:0] be;
	logic [31:0] rdat;
	modport port (output wr, output wdat, output be, input rdat);
	modport regs (input wr, input wdat, input be, output rdat);
endinterface
`default_nettype wire

// *** rtl/wb_cfg_port.sv ***
// Purpose: Classic Wishbone slave in front of the configuration word.
// Assumes: Master holds the request until it samples ack.
// Notes: Ack rises one cycle after the request and lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module wb_cfg_port #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Register side
	cfg_bus_if.port b
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
	} port_state_t;

	port_state_t q, d;
	logic hit;

	assign hit = adr_i[ADDR_W-1:2] == l1cfg_pkg::CFG_OFFSET[ADDR_W-1:2];
	// The write lands on the edge where the master samples ack, so no retry can double it.
	assign b.wr = cyc_i && stb_i && we_i && q.ack && hit;
	assign b.wdat = dat_i;
	assign b.be = sel_i;

	always_comb begin
		d = q;
		d.ack = cyc_i && stb_i && !q.ack;
		// Unmapped addresses still get ack, with zero read data.
		d.rdat = (hit && cyc_i && stb_i) ? b.rdat : 32'h00000000;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dat_o = q.rdat;
	assign ack_o = q.ack;
endmodule
`default_nettype wire

// *** rtl/l1_cache_config_control.sv ***
// Purpose: Level-one cache configuration register and the controls it drives.
// Assumes: Cache datapaths sit outside and answer invalidation with a done pulse.
// Notes: Enables are gated so a forbidden mix never reaches the caches.
`timescale 1ns/1ps
`default_nettype none
module l1_cache_config_control #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Cache controller side
	input wire logic irq_pending_i,
	input wire logic [2:0] fill_dec_i,
	input wire logic pm_inval_done_i,
	input wire logic dm_inval_done_i,
	// Cache controls
	output logic instr_cache_on_o,
	output logic pm_cache_on_o,
	output logic dm_cache_on_o,
	output logic pm_writeback_en_o,
	output logic dm_writeback_en_o,
	output logic [1:0] pm_lock_o,
	output logic [1:0] dm_lock_o,
	output logic [10:0] pm_size_kbits_o,
	output logic [10:0] dm_size_kbits_o,
	output logic pm_invalidate_o,
	output logic dm_invalidate_o,
	output logic [2:0] fill_o,
	output logic [2:0] through_o
);
	if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr_w
		$error("ADDR_W must lie between 3 and 8.");
	end

	typedef struct packed {
		logic [31:0] cfg;
		logic ic_on;
		logic pm_on;
		logic dm_on;
		logic pm_wb;
		logic dm_wb;
		logic [1:0] pm_lock;
		logic [1:0] dm_lock;
		logic [10:0] pm_kb;
		logic [10:0] dm_kb;
		logic [2:0] fill;
		logic [2:0] through;
	} cfg_state_t;

	cfg_state_t q, d;
	cfg_bus_if b ();
	logic [31:0] merged;
	logic all_on;
	logic bypass;

	wb_cfg_port #(
		.ADDR_W(ADDR_W)
	) u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.b(b.port)
	);

	assign b.rdat = q.cfg;

	always_comb begin
		d = q;
		merged = (q.cfg & ~l1cfg_pkg::be_mask(b.be)) | (b.wdat & l1cfg_pkg::be_mask(b.be));
		merged = merged & l1cfg_pkg::CFG_RW_MASK;
		if (b.wr) begin
			d.cfg = merged;
		end
		// Invalidation stays requested until the cache reports done; a new request in the done cycle wins.
		d.cfg[l1cfg_pkg::B_PM_INV] = (q.cfg[l1cfg_pkg::B_PM_INV] && !pm_inval_done_i)
			|| (b.wr && merged[l1cfg_pkg::B_PM_INV]);
		d.cfg[l1cfg_pkg::B_DM_INV] = (q.cfg[l1cfg_pkg::B_DM_INV] && !dm_inval_done_i)
			|| (b.wr && merged[l1cfg_pkg::B_DM_INV]);
		// Program and data caches only run when all three enables are set together.
		all_on = d.cfg[l1cfg_pkg::B_IC_ON] && d.cfg[l1cfg_pkg::B_PM_ON] && d.cfg[l1cfg_pkg::B_DM_ON];
		d.ic_on = d.cfg[l1cfg_pkg::B_IC_ON];
		d.pm_on = all_on;
		d.dm_on = all_on;
		d.pm_wb = d.cfg[l1cfg_pkg::B_PM_WB];
		d.dm_wb = d.cfg[l1cfg_pkg::B_DM_WB];
		d.pm_lock = {d.cfg[l1cfg_pkg::B_PM_LCK1], d.cfg[l1cfg_pkg::B_PM_LCK0]};
		d.dm_lock = {d.cfg[l1cfg_pkg::B_DM_LCK1], d.cfg[l1cfg_pkg::B_DM_LCK0]};
		d.pm_kb = l1cfg_pkg::size_kbits(d.cfg[l1cfg_pkg::B_PM_SIZE +: 2]);
		d.dm_kb = l1cfg_pkg::size_kbits(d.cfg[l1cfg_pkg::B_DM_SIZE +: 2]);
		// The bypass uses the setting already in force, never one being written this cycle.
		bypass = q.cfg[l1cfg_pkg::B_FIRQ] && irq_pending_i;
		d.fill = fill_dec_i & {3{!bypass}};
		d.through = fill_dec_i & {3{bypass}};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.cfg <= l1cfg_pkg::CFG_RESET;
			q.pm_kb <= l1cfg_pkg::SIZE_BASE_KBITS;
			q.dm_kb <= l1cfg_pkg::SIZE_BASE_KBITS;
		end else begin
			q <= d;
		end
	end

	assign instr_cache_on_o = q.ic_on;
	assign pm_cache_on_o = q.pm_on;
	assign dm_cache_on_o = q.dm_on;
	assign pm_writeback_en_o = q.pm_wb;
	assign dm_writeback_en_o = q.dm_wb;
	assign pm_lock_o = q.pm_lock;
	assign dm_lock_o = q.dm_lock;
	assign pm_size_kbits_o = q.pm_kb;
	assign dm_size_kbits_o = q.dm_kb;
	assign pm_invalidate_o = q.cfg[l1cfg_pkg::B_PM_INV];
	assign dm_invalidate_o = q.cfg[l1cfg_pkg::B_DM_INV];
	assign fill_o = q.fill;
	assign through_o = q.through;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Checks watch the controls exactly as the caches see them, one edge after the cause.
	// A control that lags by more than that edge would let one fill slip through unchanged.

	a_fill_goes_through: assert property (
		(fill_dec_i[l1cfg_pkg::FILL_DM] && irq_pending_i && q.cfg[l1cfg_pkg::B_FIRQ])
		|=> (through_o[l1cfg_pkg::FILL_DM] && !fill_o[l1cfg_pkg::FILL_DM]))
		else $error("Data fill was not turned into an uncached access.");

	a_fill_kept_normal: assert property (
		(fill_dec_i[l1cfg_pkg::FILL_IC] && !irq_pending_i) |=> (fill_o[l1cfg_pkg::FILL_IC] && !through_o[l1cfg_pkg::FILL_IC]))
		else $error("Instruction fill was bypassed with no interrupt pending.");

	a_pm_wb_write: assert property (
		(b.wr && b.be[2]) |=> (pm_writeback_en_o == $past(b.wdat[l1cfg_pkg::B_PM_WB])))
		else $error("Program write-back enable did not follow the write.");

	a_pm_inval_hold: assert property (
		((b.wr && b.be[2] && b.wdat[l1cfg_pkg::B_PM_INV]) || (pm_invalidate_o && !pm_inval_done_i))
		|=> pm_invalidate_o)
		else $error("Program invalidate dropped before done.");

	a_pm_lock_ways: assert property (
		(b.wr && b.be[2]) |=> (pm_lock_o == $past(b.wdat[l1cfg_pkg::B_PM_LCK0 +: 2])))
		else $error("Program way locks did not follow the write.");

	a_pm_size_code: assert property (
		pm_size_kbits_o == (l1cfg_pkg::SIZE_BASE_KBITS << b.rdat[l1cfg_pkg::B_PM_SIZE +: 2]))
		else $error("Program cache size does not match its code.");

	a_dm_wb_write: assert property (
		(b.wr && b.be[1]) |=> (dm_writeback_en_o == $past(b.wdat[l1cfg_pkg::B_DM_WB])))
		else $error("Data write-back enable did not follow the write.");

	a_dm_inval_done: assert property (
		(dm_invalidate_o && dm_inval_done_i && !b.wr) |=> !dm_invalidate_o)
		else $error("Data invalidate did not clear on done.");

	a_dm_lock_ways: assert property (
		(b.wr && b.be[1]) |=> (dm_lock_o == $past(b.wdat[l1cfg_pkg::B_DM_LCK0 +: 2])))
		else $error("Data way locks did not follow the write.");

	a_dm_size_code: assert property (
		dm_size_kbits_o == (l1cfg_pkg::SIZE_BASE_KBITS << b.rdat[l1cfg_pkg::B_DM_SIZE +: 2]))
		else $error("Data cache size does not match its code.");

	a_ic_on_write: assert property (
		(b.wr && b.be[0]) |=> (instr_cache_on_o == $past(b.wdat[l1cfg_pkg::B_IC_ON])))
		else $error("Instruction cache enable did not follow the write.");

	a_dm_on_gated: assert property (
		dm_cache_on_o |-> (instr_cache_on_o && pm_cache_on_o))
		else $error("Data cache on without both other caches.");

	a_reserved_zero: assert property (
		(b.rdat & ~l1cfg_pkg::CFG_RW_MASK) == 32'h00000000)
		else $error("Reserved configuration bits read nonzero.");

	a_pm_inval_done: assert property (
		(pm_invalidate_o && pm_inval_done_i && !b.wr) |=> !pm_invalidate_o)
		else $error("Program invalidate did not clear on done.");

	a_dm_inval_hold: assert property (
		((b.wr && b.be[1] && b.wdat[l1cfg_pkg::B_DM_INV]) || (dm_invalidate_o && !dm_inval_done_i))
		|=> dm_invalidate_o)
		else $error("Data invalidate dropped before done.");

	a_pm_on_gated: assert property (
		pm_cache_on_o |-> (instr_cache_on_o && dm_cache_on_o))
		else $error("Program cache on without both other caches.");

	a_pm_fill_through: assert property (
		(fill_dec_i[l1cfg_pkg::FILL_PM] && irq_pending_i && q.cfg[l1cfg_pkg::B_FIRQ])
		|=> (through_o[l1cfg_pkg::FILL_PM] && !fill_o[l1cfg_pkg::FILL_PM]))
		else $error("Program fill was not turned into an uncached access.");

	a_dm_fill_normal: assert property (
		(fill_dec_i[l1cfg_pkg::FILL_DM] && !(irq_pending_i && q.cfg[l1cfg_pkg::B_FIRQ]))
		|=> (fill_o[l1cfg_pkg::FILL_DM] && !through_o[l1cfg_pkg::FILL_DM]))
		else $error("Data fill was bypassed with the fast option off or no interrupt.");

	// Covers mark that each main scenario was reached at least once.
	c_all_caches_on: cover property (dm_cache_on_o && pm_cache_on_o && instr_cache_on_o);
	c_through_access: cover property (|through_o);
	c_inval_done: cover property (pm_invalidate_o ##1 !pm_invalidate_o);
	c_dm_inval_done: cover property (dm_invalidate_o ##1 !dm_invalidate_o);
	c_bypass_all: cover property ((fill_dec_i == 3'h7) && irq_pending_i && q.cfg[l1cfg_pkg::B_FIRQ]);
endmodule
`default_nettype wire

// *** dv/l1_cache_config_control_bench.sv ***
// Purpose: Self-checking bench for the cache configuration block.
// Assumes: Register at byte offset 0x00; ack comes one cycle after the request.
// Notes: Invalidate bits are kept out of random writes so that read-back stays predictable.
`timescale 1ns/1ps
`default_nettype none
module l1_cache_config_control_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, irq_pending_i = 1'b0;
	logic pm_inval_done_i = 1'b0, dm_inval_done_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0, s;
	logic [31:0] dat_i = 32'h0, dat_o, model, rd, d;
	logic [2:0] fill_dec_i = 3'h0, fill_o, through_o, pfd;
	logic ack_o, instr_cache_on_o, pm_cache_on_o, dm_cache_on_o, pm_writeback_en_o, dm_writeback_en_o;
	logic pm_invalidate_o, dm_invalidate_o, pirq, byp;
	logic [1:0] pm_lock_o, dm_lock_o;
	logic [10:0] pm_size_kbits_o, dm_size_kbits_o;
	logic [31:0] corner [4] = '{32'h00010101, 32'h00010100, 32'hffffffff, 32'h00000001};
	int miscompares = 0;
	int check_count = 0;
	integer seed = 32'h6968adf3;

	l1_cache_config_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_pending_i(irq_pending_i), .fill_dec_i(fill_dec_i), .pm_inval_done_i(pm_inval_done_i),
		.dm_inval_done_i(dm_inval_done_i), .instr_cache_on_o(instr_cache_on_o), .pm_cache_on_o(pm_cache_on_o),
		.dm_cache_on_o(dm_cache_on_o), .pm_writeback_en_o(pm_writeback_en_o),
		.dm_writeback_en_o(dm_writeback_en_o), .pm_lock_o(pm_lock_o), .dm_lock_o(dm_lock_o),
		.pm_size_kbits_o(pm_size_kbits_o), .dm_size_kbits_o(dm_size_kbits_o),
		.pm_invalidate_o(pm_invalidate_o), .dm_invalidate_o(dm_invalidate_o), .fill_o(fill_o),
		.through_o(through_o));

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nd, input logic [3:0] be);
		logic [31:0] m;
		for (int b = 0; b < 4; b++) m[8*b +: 8] = {8{be[b]}};
		return ((old & ~m) | (nd & m)) & l1cfg_pkg::CFG_RW_MASK;
	endfunction

	function automatic logic [10:0] size(input logic [1:0] c);
		return 11'h080 << c;
	endfunction

	// Entered right after a rising edge; holds the request until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= be;
		dat_i <= wd;
		// Only the watchdog ends a wait that never sees ack.
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Waits an extra edge so derived outputs registered from the word have settled.
	task automatic outs;
		@(posedge clk_i);
		#1;
		chk(32'(instr_cache_on_o), 32'(model[0]));
		chk(32'({pm_cache_on_o, dm_cache_on_o}), 32'({2{&{model[0], model[8], model[16]}}}));
		chk(32'({pm_writeback_en_o, pm_lock_o}), 32'({model[23], model[21:20]}));
		chk(32'({dm_writeback_en_o, dm_lock_o}), 32'({model[15], model[13:12]}));
		chk(32'({pm_size_kbits_o, dm_size_kbits_o}), 32'({size(model[18:17]), size(model[10:9])}));
		@(posedge clk_i);
	endtask

	task automatic tally_and_finish;
		$display("Counts: %0d compares, %0d mismatches", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		model = 32'h0;
		wb(1'b0, 8'h00, 4'hf, 32'h0);
		chk(rd, 32'h0);
		outs;
		$display("Test reset done");
		for (int i = 0; i < 28; i++) begin
			d = (i < 4) ? corner[i] : $random(seed);
			s = (i < 4) ? 4'hf : 4'($random(seed));
			d = d & ~32'h00404000;
			wb(1'b1, 8'h00, s, d);
			model = merge(model, d, s);
			wb(1'b0, 8'h00, 4'hf, 32'h0);
			chk(rd, model);
			outs;
		end
		wb(1'b1, 8'h04, 4'hf, 32'hffffffff);
		wb(1'b0, 8'h00, 4'hf, 32'h0);
		chk(rd, model);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(rd, 32'h0);
		$display("Test registers done");
		wb(1'b1, 8'h00, 4'hf, model | 32'h00404000);
		repeat (3) @(posedge clk_i);
		#1;
		chk(32'({pm_invalidate_o, dm_invalidate_o}), 32'h3);
		wb(1'b1, 8'h00, 4'hf, model);
		repeat (3) @(posedge clk_i);
		#1;
		chk(32'({pm_invalidate_o, dm_invalidate_o}), 32'h3);
		@(posedge clk_i);
		pm_inval_done_i <= 1'b1;
		dm_inval_done_i <= 1'b1;
		@(posedge clk_i);
		pm_inval_done_i <= 1'b0;
		dm_inval_done_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(32'({pm_invalidate_o, dm_invalidate_o}), 32'h0);
		$display("Test invalidate done");
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_i);
			model[24] = 1'(f);
			{model[16], model[8], model[0]} = 3'h7;
			wb(1'b1, 8'h00, 4'hf, model);
			outs;
			repeat (40) begin
				pfd = fill_dec_i;
				pirq = irq_pending_i;
				@(posedge clk_i);
				fill_dec_i <= 3'($random(seed));
				irq_pending_i <= 1'($random(seed));
				#1;
				byp = model[24] & pirq;
				chk(32'({fill_o, through_o}), 32'({byp ? 3'h0 : pfd, byp ? pfd : 3'h0}));
			end
		end
		$display("Test fill bypass done");
		tally_and_finish;
	end

	initial begin
		#100000;
		miscompares++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
